//--- dmm_pkg.sv
// shared constants and carrier types for the dual mode multiplier
package dmm_pkg;
	localparam int WIDE_W = 18;
	localparam int NARROW_W = 9;
	localparam int PROD_W = 2 * WIDE_W;
	localparam int NPROD_W = 2 * NARROW_W;

	// wishbone register byte offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_PROD_LO = 4'h4;
	localparam logic [3:0] OFS_PROD_HI = 4'h8;

	// control register field positions
	localparam int CTRL_MODE = 0;
	localparam int CTRL_REG_A = 1;
	localparam int CTRL_REG_B = 2;
	localparam int CTRL_REG_RES = 3;
	localparam int CTRL_REG_SA = 4;
	localparam int CTRL_REG_SB = 5;
	localparam int CTRL_REG_A1 = 6;
	localparam int CTRL_REG_B1 = 7;
	localparam int CTRL_REG_RES1 = 8;
	localparam int CTRL_W = 9;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

	// product high word field positions
	localparam int HI_SIGNED0 = 8;
	localparam int HI_SIGNED1 = 9;
	localparam int HI_MODE = 10;

	// operands and sign controls as they arrive from the fabric
	typedef struct packed {
		logic [WIDE_W-1:0] a;
		logic [WIDE_W-1:0] b;
		logic sign_a;
		logic sign_b;
	} dmm_operand_t;

	// product bundle: wide, or {upper, lower} narrow pair
	typedef struct packed {
		logic [PROD_W-1:0] value;
		logic signed1;
		logic signed0;
	} dmm_product_t;
endpackage

//--- dmm_lane.sv
// one full precision multiplier lane with per-operand sign selection
module dmm_lane #(
	parameter int W = 18
) (
	// operands
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	// sign controls, high means two's complement
	input wire logic sign_a,
	input wire logic sign_b,
	// product, never truncated
	output logic [2*W-1:0] p
);
	logic signed [W:0] a_ext;
	logic signed [W:0] b_ext;
	logic signed [2*W+1:0] full;

	// one extra bit lets unsigned and signed share a signed multiplier
	assign a_ext = $signed({sign_a & a[W-1], a});
	assign b_ext = $signed({sign_b & b[W-1], b});
	assign full = a_ext * b_ext;
	// the top two bits are pure sign extension, nothing is lost
	assign p = full[2*W-1:0];
endmodule // dmm_lane

//--- dmm_core.sv
// dual mode multiplier: one 18x18 or two 9x9, optional registers, wishbone control
module dmm_core (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// classic wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// fabric datapath
	input wire logic mul_ce,
	input wire dmm_pkg::dmm_operand_t opnd,
	output dmm_pkg::dmm_product_t prod
);
	typedef struct packed {
		logic [dmm_pkg::CTRL_W-1:0] ctrl;
		logic [dmm_pkg::WIDE_W-1:0] a_q;
		logic [dmm_pkg::WIDE_W-1:0] b_q;
		logic sa_q;
		logic sb_q;
		dmm_pkg::dmm_product_t res_q;
		dmm_pkg::dmm_product_t out;
		// bus answer, one cycle pulse
		logic ack;
		logic [31:0] rdat;
	} dmm_state_t;

	localparam int NW = dmm_pkg::NARROW_W;
	localparam int WW = dmm_pkg::WIDE_W;
	localparam int NP = dmm_pkg::NPROD_W;

	dmm_state_t st_r;
	dmm_state_t st_nxt;

	logic narrow;
	logic sel_a0;
	logic sel_a1;
	logic sel_b0;
	logic sel_b1;
	logic sel_r0;
	logic sel_r1;
	logic [WW-1:0] a_eff;
	logic [WW-1:0] b_eff;
	logic sa_eff;
	logic sb_eff;
	logic [dmm_pkg::PROD_W-1:0] p_wide;
	logic [NP-1:0] p_lo;
	logic [NP-1:0] p_hi;
	dmm_pkg::dmm_product_t p_now;
	dmm_pkg::dmm_product_t p_eff;

	// mode decides which control bits steer the upper half
	assign narrow = st_r.ctrl[dmm_pkg::CTRL_MODE];
	assign sel_a0 = st_r.ctrl[dmm_pkg::CTRL_REG_A];
	assign sel_b0 = st_r.ctrl[dmm_pkg::CTRL_REG_B];
	assign sel_r0 = st_r.ctrl[dmm_pkg::CTRL_REG_RES];
	// wide mode treats the operand as one 18 bit unit
	// narrower wide-mode operands must arrive already sign or zero extended
	assign sel_a1 = narrow ? st_r.ctrl[dmm_pkg::CTRL_REG_A1] : sel_a0;
	assign sel_b1 = narrow ? st_r.ctrl[dmm_pkg::CTRL_REG_B1] : sel_b0;
	assign sel_r1 = narrow ? st_r.ctrl[dmm_pkg::CTRL_REG_RES1] : sel_r0;

	// input register or bypass, per 9 bit section
	always_comb begin
		a_eff = opnd.a;
		b_eff = opnd.b;
		sa_eff = opnd.sign_a;
		sb_eff = opnd.sign_b;
		if (sel_a0) begin
			a_eff[NW-1:0] = st_r.a_q[NW-1:0];
		end
		if (sel_a1) begin
			a_eff[WW-1:NW] = st_r.a_q[WW-1:NW];
		end
		if (sel_b0) begin
			b_eff[NW-1:0] = st_r.b_q[NW-1:0];
		end
		if (sel_b1) begin
			b_eff[WW-1:NW] = st_r.b_q[WW-1:NW];
		end
		// each sign control has its own register select
		if (st_r.ctrl[dmm_pkg::CTRL_REG_SA]) begin
			sa_eff = st_r.sa_q;
		end
		if (st_r.ctrl[dmm_pkg::CTRL_REG_SB]) begin
			sb_eff = st_r.sb_q;
		end
	end

	dmm_lane #(.W(WW)) u_wide (
		.a(a_eff),
		.b(b_eff),
		.sign_a(sa_eff),
		.sign_b(sb_eff),
		.p(p_wide)
	);

	// both narrow lanes see the single pair of sign controls
	dmm_lane #(.W(NW)) u_lo (
		.a(a_eff[NW-1:0]),
		.b(b_eff[NW-1:0]),
		.sign_a(sa_eff),
		.sign_b(sb_eff),
		.p(p_lo)
	);

	dmm_lane #(.W(NW)) u_hi (
		.a(a_eff[WW-1:NW]),
		.b(b_eff[WW-1:NW]),
		.sign_a(sa_eff),
		.sign_b(sb_eff),
		.p(p_hi)
	);

	always_comb begin
		p_now.value = narrow ? {p_hi, p_lo} : p_wide;
		// both flags follow the same pair of effective signs
		p_now.signed0 = sa_eff | sb_eff;
		p_now.signed1 = sa_eff | sb_eff;
		p_eff = p_now;
		// lower section: 18 bits narrow, low half of the 36 bits wide
		if (sel_r0) begin
			p_eff.value[NP-1:0] = st_r.res_q.value[NP-1:0];
			p_eff.signed0 = st_r.res_q.signed0;
		end
		// upper section copies the lower select in wide mode
		if (sel_r1) begin
			p_eff.value[dmm_pkg::PROD_W-1:NP] = st_r.res_q.value[dmm_pkg::PROD_W-1:NP];
			p_eff.signed1 = st_r.res_q.signed1;
		end
	end

	always_comb begin
		logic req;
		logic wr;
		req = 1'b0;
		wr = 1'b0;
		st_nxt = st_r;

		// datapath registers all move on the one shared enable
		if (mul_ce) begin
			st_nxt.a_q = opnd.a;
			st_nxt.b_q = opnd.b;
			st_nxt.sa_q = opnd.sign_a;
			st_nxt.sb_q = opnd.sign_b;
			st_nxt.res_q = p_now;
			// boundary flop so outputs come from a register
			st_nxt.out = p_eff;
		end

		// the bus side ignores mul_ce, so control can change while the datapath sleeps
		// one wait state: ack the cycle after the request, drop it next
		req = wb_cyc_i & wb_stb_i & ~st_r.ack;
		wr = req & wb_we_i;
		st_nxt.ack = req;
		st_nxt.rdat = 32'h0000_0000;
		if (wr && wb_adr_i == dmm_pkg::OFS_CTRL) begin
			if (wb_sel_i[0]) begin
				st_nxt.ctrl[7:0] = wb_dat_i[7:0];
			end
			// bit 8 is the only control bit in the second byte lane
			if (wb_sel_i[1]) begin
				st_nxt.ctrl[dmm_pkg::CTRL_W-1:8] = wb_dat_i[dmm_pkg::CTRL_W-1:8];
			end
		end
		// unmapped offsets still ack, reading zero
		if (req && !wb_we_i) begin
			unique case (wb_adr_i)
				dmm_pkg::OFS_CTRL: begin
					st_nxt.rdat[dmm_pkg::CTRL_W-1:0] = st_r.ctrl;
				end
				dmm_pkg::OFS_PROD_LO: begin
					st_nxt.rdat = st_r.out.value[31:0];
				end
				dmm_pkg::OFS_PROD_HI: begin
					st_nxt.rdat[3:0] = st_r.out.value[dmm_pkg::PROD_W-1:32];
					st_nxt.rdat[dmm_pkg::HI_SIGNED0] = st_r.out.signed0;
					st_nxt.rdat[dmm_pkg::HI_SIGNED1] = st_r.out.signed1;
					st_nxt.rdat[dmm_pkg::HI_MODE] = narrow;
				end
				default: begin
					st_nxt.rdat = 32'h0000_0000;
				end
			endcase
		end
	end

	// the one asynchronous clear covers every register of the block
	// clear does not wait for mul_ce, so a stalled datapath still resets
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= '0;
			st_r.ctrl <= dmm_pkg::CTRL_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign wb_ack_o = st_r.ack;
	assign wb_dat_o = st_r.rdat;
	assign prod = st_r.out;
endmodule // dmm_core

//--- dmm_core_properties.sv
// port-level assertions for the dual mode multiplier
module dmm_core_chk (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// datapath
	input wire logic mul_ce,
	input wire dmm_pkg::dmm_operand_t opnd,
	input wire dmm_pkg::dmm_product_t prod
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] ctrl_r;
	logic [8:0] ctrl_nxt;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	function automatic logic [35:0] expv(dmm_pkg::dmm_operand_t o, logic n);
		logic signed [37:0] w;
		logic signed [19:0] l0;
		logic signed [19:0] l1;
		w = $signed({o.sign_a & o.a[17], o.a}) * $signed({o.sign_b & o.b[17], o.b});
		l0 = $signed({o.sign_a & o.a[8], o.a[8:0]}) * $signed({o.sign_b & o.b[8], o.b[8:0]});
		l1 = $signed({o.sign_a & o.a[17], o.a[17:9]}) * $signed({o.sign_b & o.b[17], o.b[17:9]});
		return n ? {l1[17:0], l0[17:0]} : w[35:0];
	endfunction
	// mirror of the control register, updated at the taking edge like the design
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == dmm_pkg::OFS_CTRL) begin
			if (wb_sel_i[0]) ctrl_nxt[7:0] = wb_dat_i[7:0];
			if (wb_sel_i[1]) ctrl_nxt[8] = wb_dat_i[8];
		end
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) ctrl_r <= 9'h000;
		else ctrl_r <= ctrl_nxt;
	end
	sequence bus_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	ack_next_a: assert property (bus_take |=> wb_ack_o) else $error("no ack");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat not 0");
	prod_value_a: assert property ((ctrl_r[8:1] == 8'h00 && mul_ce)
		|=> prod.value == $past(expv(opnd, ctrl_r[0]))) else $error("bad product");
	prod_sign_a: assert property ((ctrl_r[8:1] == 8'h00 && mul_ce)
		|=> prod.signed0 == $past(opnd.sign_a | opnd.sign_b)) else $error("bad sign");
	lane_sign_a: assert property ((ctrl_r == 9'h001 && mul_ce)
		|=> prod.signed1 == $past(opnd.sign_a | opnd.sign_b)) else $error("lane signs differ");
	sequence sb_reg_run;
		(ctrl_r[5:3] == 3'h4 && !ctrl_r[8] && mul_ce)[*2];
	endsequence
	sign_reg_a: assert property (sb_reg_run |=> prod.signed0
		== ($past(opnd.sign_a) | $past(opnd.sign_b, 2))) else $error("sign reg not used");
	ce_hold_a: assert property (!mul_ce |=> $stable(prod)) else $error("moved without ce");
	res_reg_a: assert property ((ctrl_r == 9'h008 && mul_ce)[*2]
		|=> prod.value == $past(expv(opnd, 1'b0), 2)) else $error("bad latency");
endmodule // dmm_core_chk

//--- dmm_fabric.sv
// behavioural fabric launching operands and enable
module dmm_fabric (
	// clock
	input wire logic core_clk,
	// toward the multiplier
	output dmm_pkg::dmm_operand_t opnd,
	output logic mul_ce
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		opnd = '0;
		mul_ce = 1'b0;
	end
	// one sign pair only, so both narrow lanes always agree
	task automatic put(input logic [17:0] a, input logic [17:0] b, input logic sa, input logic sb,
		input logic ce);
		@(posedge core_clk);
		opnd <= {a, b, sa, sb};
		mul_ce <= ce;
	endtask
endmodule // dmm_fabric

//--- dmm_core_tb_top.sv
// self-checking bench for the dual mode multiplier
module dmm_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic mul_ce;
	dmm_pkg::dmm_operand_t opnd;
	dmm_pkg::dmm_product_t prod;
	int err_total = 0;
	int tests_run = 0;
	always #5 core_clk = ~core_clk;
	dmm_core i_dmm_core (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .mul_ce(mul_ce), .opnd(opnd), .prod(prod));
	dmm_fabric i_dmm_fabric (.core_clk(core_clk), .opnd(opnd), .mul_ce(mul_ce));
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge core_clk);
		while (ack !== 1'b1) @(posedge core_clk);
		d = rdat;
		cyc <= 1'b0;
		if (!w) chk(36'(d), 36'(wdat));
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic sign_table();
		logic [35:0] e[4] = '{36'hffff80001, 36'hffffc0001, 36'hffffc0001, 36'h000000001};
		for (int i = 0; i < 4; i++) begin
			i_dmm_fabric.put(18'h3ffff, 18'h3ffff, i[1], i[0], 1'b1);
			@(posedge core_clk);
			#1 chk(prod.value, e[i]);
		end
		i_dmm_fabric.put(18'h00002, 18'h00002, 1'b0, 1'b0, 1'b0);
		@(posedge core_clk);
		#1 chk(prod.value, 36'h1);
	endtask
	task automatic narrow_pair();
		bus(1'b1, dmm_pkg::OFS_CTRL, 32'h1);
		i_dmm_fabric.put(18'h3fe03, 18'h005fe, 1'b1, 1'b0, 1'b1);
		@(posedge core_clk);
		#1 chk(prod.value, 36'hffff805fa);
		chk(36'({prod.signed1, prod.signed0}), 36'h3);
		bus(1'b0, dmm_pkg::OFS_PROD_HI, 32'h0000_070f);
	endtask
	task automatic reg_paths();
		bus(1'b1, dmm_pkg::OFS_CTRL, 32'h23);
		bus(1'b0, dmm_pkg::OFS_CTRL, 32'h23);
		i_dmm_fabric.put(18'h00005, 18'h00000, 1'b0, 1'b1, 1'b1);
		i_dmm_fabric.put(18'h00607, 18'h3fffe, 1'b0, 1'b0, 1'b1);
		@(posedge core_clk);
		#1 chk(prod.value, 36'hffff7fff6);
		chk(36'({prod.signed1, prod.signed0}), 36'h3);
	endtask
	task automatic res_latency();
		bus(1'b1, dmm_pkg::OFS_CTRL, 32'h8);
		i_dmm_fabric.put(18'h00010, 18'h00010, 1'b0, 1'b0, 1'b1);
		i_dmm_fabric.put(18'h00020, 18'h00010, 1'b0, 1'b0, 1'b1);
		@(posedge core_clk);
		#1 chk(prod.value, 36'h100);
		@(posedge core_clk);
		#1 chk(prod.value, 36'h200);
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		bus(1'b0, 4'hc, 32'h0);
		sign_table();
		bus(1'b0, dmm_pkg::OFS_PROD_LO, 32'h1);
		narrow_pair();
		res_latency();
		reg_paths();
		test_done();
	end
	initial begin
		#100us;
		err_total++;
		test_done();
	end
endmodule // dmm_core_tb_top
bind dmm_core dmm_core_chk i_dmm_core_chk (.core_clk(core_clk), .sys_rst(sys_rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.mul_ce(mul_ce), .opnd(opnd), .prod(prod));
